// file: shared/ifc_pkg.sv
package ifc_pkg;
   // register byte addresses
   localparam logic [3:0] ifc_addr_ctrl = 4'h0;
   localparam logic [3:0] ifc_addr_low = 4'h4;
   localparam logic [3:0] ifc_addr_mid = 4'h8;
   localparam logic [3:0] ifc_addr_high = 4'hc;
   // control register fields
   localparam int ifc_clr_bit = 7;
   localparam int ifc_fm_bit = 6;
   localparam int ifc_am_bit = 5;
   localparam int ifc_gate_lsb = 0;
   localparam int ifc_gate_w = 4;
   localparam logic [7:0] ifc_ctrl_rst = 8'h00;
   // count width
   localparam int ifc_cnt_w = 17;
   // timebase
   localparam int ifc_clk_khz = 100000;
   localparam int ifc_tick_us = 1000;
   localparam int ifc_tick_cyc = ifc_clk_khz * ifc_tick_us / 1000;
   localparam int ifc_half_cyc = ifc_tick_cyc / 2;
   // bus answers
   localparam logic [1:0] ifc_resp_okay = 2'b00;
   localparam logic [1:0] ifc_resp_slverr = 2'b10;

   typedef enum logic [1:0] {
      ifc_idle,
      ifc_arm,
      ifc_gate,
      ifc_done
   } ifc_state_t;
endpackage : ifc_pkg

// file: src/ifc_counter.sv
`timescale 1ns/1ps
// Operation
// - count is a 17-bit up-counter read through three byte registers
// - writes to the readout registers do not touch the count
// - gate field picks 1 to 15 ms gate
// - bits 6 and 5 of control select fm or am input
// - unselected input pin gets its pull-down enabled while the other input is selected; none when neither is
// - am input counts each rising edge directly
// - fm input passes a divide-by-two stage before the counter
// - reset clears the count to zero
// - count is held after gate closes until cleared or restarted
// - control bit 7 written as one clears the held count
// - halt keeps count and state unchanged unless the control register is written
// - control register is 8 bits, all zero at reset
// - gate built from free-running 1 ms pulses, whole number of them
// - counting starts at next falling edge of the 1 ms timebase
// - 1 ms timebase divided from the main clock
// - fm prescaler holding an odd rise at gate close or deselect counts one extra
// - am high at gate open counts one extra
module ifc_counter
   import ifc_pkg::*;
#(
   parameter int tick_cycles = ifc_tick_cyc
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic halt,
   input wire logic fm_input_pin,
   input wire logic am_input_pin,
   output logic fm_pulldown_en,
   output logic am_pulldown_en,
   output logic gate_open,
   output logic busy,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // elaboration checks: the timebase counter is 20 bits wide and needs
   // at least two cycles per tick to make a high and a low half
   if (tick_cycles < 2 || tick_cycles > 1048575) begin : g_chk
      $error("tick_cycles out of range");
   end
   // the readout splits the count into three bytes, high byte one bit
   if (ifc_cnt_w != 17) begin : g_chk_cnt
      $error("count width must be 17");
   end
   // the gate field must fit the 4-bit remaining-ticks counter
   if (ifc_gate_w != 4) begin : g_chk_gate
      $error("gate field must be 4 bits");
   end

   // bus state
   logic aw_hold_ff;
   logic w_hold_ff;
   logic [3:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic wstrb0_ff;
   // channel readies are registered so that no bus output is
   // combinational; each is computed one cycle ahead from next state
   logic awready_ff;
   logic wready_ff;
   logic arready_ff;
   logic busy_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic rvalid_ff;
   logic [1:0] rresp_ff;
   logic [31:0] rdata_ff;

   // block state
   logic [7:0] ctrl_ff;
   logic [ifc_cnt_w-1:0] count_ff;
   logic [19:0] tb_cnt_ff;
   logic tb_level_ff;
   logic [3:0] gate_left_ff;
   ifc_state_t state_ff;
   logic fm_prev_ff;
   logic am_prev_ff;
   logic fm_div_ff;
   logic sel_fm_prev_ff;
   logic sel_am_prev_ff;
   logic gate_ff;
   logic pd_fm_ff;
   logic pd_am_ff;

   // byte-wide read decode
   function automatic logic [7:0] ifc_rd_byte(
      input logic [3:0] a,
      input logic [7:0] c,
      input logic [ifc_cnt_w-1:0] n
   );
      logic [7:0] r;
      r = 8'h00;
      case (a)
         ifc_addr_ctrl: r = c;
         ifc_addr_low: r = n[7:0];
         ifc_addr_mid: r = n[15:8];
         ifc_addr_high: r = {7'h00, n[16]};
         default: r = 8'h00;
      endcase
      return r;
   endfunction : ifc_rd_byte

   function automatic logic ifc_mapped(input logic [3:0] a);
      return (a == ifc_addr_ctrl) || (a == ifc_addr_low) ||
             (a == ifc_addr_mid) || (a == ifc_addr_high);
   endfunction : ifc_mapped

   // write channel capture; address and data may come in either order
   // and each is parked until its partner arrives
   wire aw_take = s_axi_awvalid && awready_ff;
   wire w_take = s_axi_wvalid && wready_ff;
   wire [3:0] wr_addr = aw_hold_ff ? awaddr_ff : s_axi_awaddr;
   wire [31:0] wr_data = w_hold_ff ? wdata_ff : s_axi_wdata;
   wire wr_strb0 = w_hold_ff ? wstrb0_ff : s_axi_wstrb[0];
   wire wr_fire = (aw_hold_ff || aw_take) && (w_hold_ff || w_take);
   wire ctrl_wr = wr_fire && wr_addr == ifc_addr_ctrl && wr_strb0;
   wire [1:0] nxt_bresp = ifc_mapped(wr_addr) ? ifc_resp_okay :
                          ifc_resp_slverr;

   // read channel; one read in flight, ready drops while data waits
   wire ar_take = s_axi_arvalid && arready_ff;
   wire [3:0] rd_addr = s_axi_araddr;

   // next channel state, used to set the readies one cycle ahead
   // so a slot is never offered while its answer is still pending
   wire nxt_aw_hold = !wr_fire && (aw_hold_ff || aw_take);
   wire nxt_w_hold = !wr_fire && (w_hold_ff || w_take);
   wire nxt_bvalid = wr_fire || (bvalid_ff && !s_axi_bready);
   wire nxt_rvalid = ar_take || (rvalid_ff && !s_axi_rready);

   // timebase: free-running 1 ms square wave, falling edge marks tick;
   // it pauses in halt so that an open gate keeps its exact length
   wire tb_step = !halt;
   wire tb_wrap = tb_step && tb_cnt_ff == 20'(tick_cycles - 1);
   wire tb_mid = tb_step && tb_cnt_ff == 20'(tick_cycles / 2 - 1);
   wire nxt_tb_level = tb_wrap ? 1'b0 :
                       tb_mid ? 1'b1 :
                       tb_level_ff;
   // tick is the high-to-low step of the square wave
   wire tb_fall = tb_level_ff && !nxt_tb_level;

   // input selection and edge logic
   wire sel_fm = ctrl_ff[ifc_fm_bit];
   wire sel_am = ctrl_ff[ifc_am_bit] && !sel_fm;
   // gate length comes from the written word, so a restart needs no
   // second write to take effect
   wire [3:0] wr_gate = wr_data[ifc_gate_lsb +: ifc_gate_w];
   // counting pauses in halt; the window itself stays open
   wire gate_run = state_ff == ifc_gate && !halt;
   // arming or gating counts as busy
   wire nxt_busy = state_ff == ifc_arm || state_ff == ifc_gate;
   wire am_rise = am_input_pin && !am_prev_ff;
   wire am_open = gate_run && sel_am && am_input_pin &&
                  (!gate_ff || !sel_am_prev_ff);
   wire am_inc = gate_run && sel_am && (am_rise || am_open);
   wire fm_fall = !fm_input_pin && fm_prev_ff;
   wire fm_div_out = gate_run && sel_fm && fm_input_pin && !fm_prev_ff &&
                     fm_div_ff;
   wire gate_close = gate_run && tb_fall && gate_left_ff == 4'h1;
   wire fm_tail = sel_fm_prev_ff && gate_ff && fm_div_ff &&
                  (gate_close || !sel_fm);
   wire fm_inc = fm_div_out || fm_tail;
   wire do_inc = am_inc || fm_inc;
   wire clr_req = ctrl_wr && wr_data[ifc_clr_bit];

   // control register, clear bit is self-clearing strobe
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_ff <= ifc_ctrl_rst;
      end else if (ctrl_wr) begin
         ctrl_ff <= {1'b0, wr_data[6:0]};
      end
   end

   // timebase divider
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tb_cnt_ff <= 20'h00000;
         tb_level_ff <= 1'b0;
      end else begin
         if (tb_step) begin
            tb_cnt_ff <= tb_wrap ? 20'h00000 : tb_cnt_ff + 20'h00001;
         end
         tb_level_ff <= nxt_tb_level;
      end
   end

   // gate sequencer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_ff <= ifc_idle;
         gate_left_ff <= 4'h0;
      end else if (ctrl_wr) begin
         state_ff <= (wr_gate != 4'h0) ? ifc_arm : ifc_idle;
         gate_left_ff <= wr_gate;
      end else if (!halt) begin
         case (state_ff)
            ifc_arm: if (tb_fall) state_ff <= ifc_gate;
            ifc_gate: if (tb_fall) begin
               gate_left_ff <= gate_left_ff - 4'h1;
               if (gate_left_ff == 4'h1) state_ff <= ifc_done;
            end
            ifc_idle, ifc_done: state_ff <= state_ff;
            default: state_ff <= ifc_idle;
         endcase
      end
   end

   // input history and fm prescaler
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fm_prev_ff <= 1'b0;
         am_prev_ff <= 1'b0;
         fm_div_ff <= 1'b0;
         sel_fm_prev_ff <= 1'b0;
         sel_am_prev_ff <= 1'b0;
         gate_ff <= 1'b0;
      end else begin
         fm_prev_ff <= fm_input_pin;
         am_prev_ff <= am_input_pin;
         sel_fm_prev_ff <= sel_fm;
         sel_am_prev_ff <= sel_am;
         // window flag ignores halt, so the gate looks open through it
         gate_ff <= state_ff == ifc_gate;
         // prescaler phase survives a halt; only gate end or deselecting fm clears it
         if (state_ff != ifc_gate || !sel_fm || fm_tail) begin
            fm_div_ff <= 1'b0;
         end else if (halt) begin
            fm_div_ff <= fm_div_ff;
         end else if (fm_input_pin && !fm_prev_ff) begin
            fm_div_ff <= !fm_div_ff;
         end else if (fm_fall) begin
            fm_div_ff <= fm_div_ff;
         end
      end
   end

   // measurement counter
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         count_ff <= '0;
      end else if (clr_req || (ctrl_wr && wr_gate != 4'h0)) begin
         count_ff <= '0;
      end else if (do_inc) begin
         count_ff <= count_ff + 17'h00001;
      end
   end // no other path changes the count

   // status and pull-down outputs
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pd_fm_ff <= 1'b0;
         pd_am_ff <= 1'b0;
         busy_ff <= 1'b0;
      end else begin
         pd_fm_ff <= sel_am;
         pd_am_ff <= sel_fm;
         busy_ff <= nxt_busy;
      end
   end

   // readies rise only when the slot will be free at the next edge;
   // all low in reset, so nothing is taken before release
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         arready_ff <= 1'b0;
      end else begin
         awready_ff <= !nxt_aw_hold && !nxt_bvalid;
         wready_ff <= !nxt_w_hold && !nxt_bvalid;
         arready_ff <= !nxt_rvalid;
      end
   end

   // axi write path
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         awaddr_ff <= 4'h0;
         wdata_ff <= 32'h00000000;
         wstrb0_ff <= 1'b0;
         bvalid_ff <= 1'b0;
         bresp_ff <= ifc_resp_okay;
      end else if (wr_fire) begin
         aw_hold_ff <= 1'b0;
         w_hold_ff <= 1'b0;
         bvalid_ff <= 1'b1;
         bresp_ff <= nxt_bresp;
      end else begin
         if (aw_take) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (w_take) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb0_ff <= s_axi_wstrb[0];
         end
         if (bvalid_ff && s_axi_bready) bvalid_ff <= 1'b0;
      end
   end

   // axi read path
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rvalid_ff <= 1'b0;
         rresp_ff <= ifc_resp_okay;
         rdata_ff <= 32'h00000000;
      end else if (ar_take) begin
         rvalid_ff <= 1'b1;
         rresp_ff <= ifc_mapped(rd_addr) ? ifc_resp_okay : ifc_resp_slverr;
         rdata_ff <= {24'h000000, ifc_rd_byte(rd_addr, ctrl_ff, count_ff)};
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   // outputs, each straight from a register
   assign s_axi_awready = awready_ff;
   assign s_axi_wready = wready_ff;
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rresp = rresp_ff;
   assign s_axi_rdata = rdata_ff;
   assign fm_pulldown_en = pd_fm_ff;
   assign am_pulldown_en = pd_am_ff;
   assign gate_open = gate_ff;
   assign busy = busy_ff;
endmodule : ifc_counter

// file: sim/ifc_if_source.sv
`timescale 1ns/1ps
module ifc_if_source #(
   parameter int per = 10
) (
   input wire logic ref_clk,
   input wire logic run,
   input wire logic lvl,
   input wire logic fm_pulldown_en,
   input wire logic am_pulldown_en,
   output logic fm_input_pin,
   output logic am_input_pin
);
   int ph_ff = 0;
   // free square wave, one rise per per clocks
   always @(posedge ref_clk) begin
      ph_ff <= (ph_ff == per - 1) ? 0 : ph_ff + 1;
   end
   // pulled-down line reads low, stopped line sits at lvl
   assign fm_input_pin = fm_pulldown_en ? 1'b0 : run ? ph_ff < per / 2 : lvl;
   assign am_input_pin = am_pulldown_en ? 1'b0 : run ? ph_ff < per / 2 : lvl;
endmodule : ifc_if_source

// file: sim/ifc_counter_asserts.sv
`timescale 1ns/1ps
module ifc_counter_asserts
   import ifc_pkg::*;
#(
   parameter int tick_cycles = ifc_tick_cyc
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic halt,
   input wire logic fm_pulldown_en,
   input wire logic am_pulldown_en,
   input wire logic gate_open,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid
);
   int gcnt_ff;
   logic [3:0] radr_ff;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   // open-gate cycles, halted ones left out
   always_ff @(posedge ref_clk) begin
      if (reset || !gate_open) gcnt_ff <= 0;
      else if (!halt) gcnt_ff <= gcnt_ff + 1;
   end
   // address of the read in flight
   always_ff @(posedge ref_clk) begin
      if (s_axi_arvalid && s_axi_arready) radr_ff <= s_axi_araddr;
   end
   property p_pd; !(fm_pulldown_en && am_pulldown_en); endproperty
   a_pd: assert property (p_pd) else $error("both pulldowns");
   property p_rst;
      $fell(reset) |-> !(gate_open || fm_pulldown_en || am_pulldown_en);
   endproperty
   a_rst: assert property (p_rst) else $error("not idle");
   property p_gmax; gate_open |-> gcnt_ff < 15 * tick_cycles; endproperty
   a_gmax: assert property (p_gmax) else $error("gate too long");
   property p_gmul;
      $fell(gate_open) |-> gcnt_ff > 0 && gcnt_ff % tick_cycles == 0;
   endproperty
   a_gmul: assert property (p_gmul) else $error("gate not whole");
   property p_halt; halt && $past(halt) && gate_open |=> gate_open; endproperty
   a_halt: assert property (p_halt) else $error("halt lost gate");
   property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rlat: assert property (p_rlat) else $error("read late");
   property p_rpad; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_rpad: assert property (p_rpad) else $error("upper bits set");
   property p_rhi;
      s_axi_rvalid && radr_ff == ifc_addr_high |-> s_axi_rdata[31:1] == 31'h0;
   endproperty
   a_rhi: assert property (p_rhi) else $error("high byte wide");
   c_gate: cover property ($rose(gate_open));
   c_halt: cover property (halt && gate_open);
   c_rhi: cover property (s_axi_rvalid && radr_ff == ifc_addr_high);
endmodule : ifc_counter_asserts

bind ifc_counter ifc_counter_asserts #(.tick_cycles(tick_cycles)) u_chk (
   .ref_clk, .reset, .halt, .fm_pulldown_en, .am_pulldown_en, .gate_open,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid
);

// file: sim/if_frequency_counter_tb.sv
`timescale 1ns/1ps
module if_frequency_counter_tb;
   import ifc_pkg::*;
   logic ref_clk, reset, halt, run, lvl, gate_open, busy;
   logic fm_input_pin, am_input_pin, fm_pulldown_en, am_pulldown_en;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
   logic [16:0] c0, c1;
   int error_cnt = 0;
   int check_count = 0;
   ifc_counter #(.tick_cycles(20)) uut (
      .ref_clk, .reset, .halt, .fm_input_pin, .am_input_pin,
      .fm_pulldown_en, .am_pulldown_en, .gate_open, .busy(busy),
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   ifc_if_source src (.ref_clk, .run, .lvl, .fm_pulldown_en,
      .am_pulldown_en, .fm_input_pin, .am_input_pin);
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // value within e..e+sl, unknowns fail
   task automatic chk(string s, logic [31:0] e, logic [31:0] g, int sl);
      check_count++;
      if (((g >= e) && (g <= e + sl)) !== 1'b1) begin
         error_cnt++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic lim(string s, int n, int m);
      chk(s, 32'h1, {31'h0, n < m}, 0);
      if (n >= m) stop_test();
   endtask : lim
   task automatic stop_test;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : stop_test
   // one write (w) or read on the register bus
   task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= {24'h0, d};
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && n < 50);
      {s_axi_bready, s_axi_rready} <= 2'h0;
      rd_v = s_axi_rdata;
      rd_r = s_axi_rresp;
      lim("bus_wait", n, 50);
   endtask : bus
   // count from the three readout bytes
   task automatic rdcnt;
      bus(1'b0, ifc_addr_low, 8'h00);
      c1[7:0] = rd_v[7:0];
      bus(1'b0, ifc_addr_mid, 8'h00);
      c1[15:8] = rd_v[7:0];
      bus(1'b0, ifc_addr_high, 8'h00);
      c1[16] = rd_v[0];
   endtask : rdcnt
   // start a gate, halt hc cycles inside it, time it
   task automatic meas(logic [7:0] c, int len, int hc);
      int n;
      int g;
      n = 0;
      g = 0;
      bus(1'b1, ifc_addr_ctrl, c);
      while (gate_open !== 1'b1 && n < 24) begin
         @(posedge ref_clk);
         n++;
      end
      lim("gate_start", n, 24);
      chk("busy", 32'h1, {31'h0, busy}, 0);
      while (gate_open === 1'b1 && g < 400) begin
         @(posedge ref_clk);
         g++;
         halt <= (g >= 10 && g < 10 + hc);
      end
      chk("gate_len", len, g, 0);
      chk("idle", 32'h0, {31'h0, busy}, 0);
   endtask : meas
   initial begin
      {reset, halt, run, lvl} = 4'h a;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 10'h0;
      s_axi_wdata = 32'h0;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 4'(i * 4), 8'h00);
         chk("reset_val", 32'h0, rd_v, 0);
      end
      bus(1'b0, 4'h2, 8'h00);
      chk("unmapped", ifc_resp_slverr, rd_r, 0);
      meas(8'h23, 60, 0);
      chk("pulldown", 32'h2, {fm_pulldown_en, am_pulldown_en}, 0);
      rdcnt();
      chk("am_count", 32'h6, c1, 1);
      c0 = c1;
      for (int i = 1; i < 4; i++) bus(1'b1, 4'(i * 4), 8'hff);
      repeat (50) @(posedge ref_clk);
      rdcnt();
      chk("held", c0, c1, 0);
      meas(8'h4f, 300, 0);
      chk("pulldown", 32'h1, {fm_pulldown_en, am_pulldown_en}, 0);
      rdcnt();
      chk("fm_count", 32'hf, c1, 1);
      bus(1'b0, ifc_addr_ctrl, 8'h00);
      chk("ctrl", 32'h4f, rd_v, 0);
      bus(1'b1, ifc_addr_ctrl, 8'h80);
      rdcnt();
      chk("cleared", 32'h0, c1, 0);
      run <= 1'b0;
      lvl <= 1'b1;
      meas(8'h22, 50, 10);
      rdcnt();
      chk("am_static", 32'h1, c1, 0);
      stop_test();
   end
endmodule : if_frequency_counter_tb
